// [verilog/sschd_top.v]
// serial setting command handler: command decode, settings, replies
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sschd_consts.vh"
// Behaviour
// - loop-drop 1/0 sets state, replies it
// - loop-drop toggle inverts, query keeps; reply
// - enabled loop-drop hangs up on drop
// - tone and loop-drop hangup kept separate
// - preset settings stored only in presets
// - per-output open-mic attenuation enable
// - wildcard single value applies to all
// - wildcard digits set each output
// - wildcard toggle/query report all outputs
// - only 9600, 19200, 38400 rates accepted
// - rate acknowledge sent at new rate
// - rate saved globally on each change
// - acknowledge waits for storage write
// - rate query returns current rate
// - level-report enable 1 on, 0 off
// - level-report toggle inverts, query keeps
module sschd_top #(
  parameter NUM_OUT = 2
) (
  // system
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // phone line
  input wire loop_drop_i,
  input wire tone_detect_i,
  output reg hangup_o,
  // setting outputs
  output reg [NUM_OUT-1:0] open_mic_atten_o,
  output reg auto_level_report_o,
  output reg [1:0] line_rate_o,
  // preset restore and global storage
  input wire preset_load_i,
  input wire [NUM_OUT+2:0] preset_dat_i,
  output wire [NUM_OUT+2:0] preset_dat_o,
  output reg nv_wr_o,
  output reg [1:0] nv_dat_o,
  input wire nv_done_i,
  input wire [1:0] nv_rate_i,
  input wire nv_rate_vld_i
);
  reg ldh_ff;
  reg tone_ff;
  reg busy_ff;
  reg done_ff;
  reg err_ff;
  reg [15:0] reply_ff;
  reg [2:0] ld_sync_ff;
  reg [2:0] tn_sync_ff;
  reg ld_st_ff;
  reg tn_st_ff;
  reg [NUM_OUT-1:0] nxt_atten;
  reg [NUM_OUT-1:0] rep_atten;
  wire wb_req;
  wire cmd_wr;
  wire [3:0] op;
  wire [3:0] val;
  wire [2:0] ch;
  wire wild;
  wire [NUM_OUT-1:0] digs;
  wire cmd_take;
  wire rate_set;
  wire cmd_bad;
  wire stat_rd;
  integer i;

  // boolean value decode shared by all boolean commands
  function bool_next;
    input cur;
    input [3:0] v;
    begin
      case (v)
        `SSCHD_VAL_ON: bool_next = 1'b1;
        `SSCHD_VAL_OFF: bool_next = 1'b0;
        `SSCHD_VAL_TOG: bool_next = ~cur;
        default: bool_next = cur;
      endcase
    end
  endfunction

  function rate_ok;
    input [1:0] r;
    begin
      rate_ok = (r == `SSCHD_RATE_9600) || (r == `SSCHD_RATE_19200) ||
        (r == `SSCHD_RATE_38400);
    end
  endfunction

  // rate code must sit in the low two value bits
  function rate_legal;
    input [3:0] v;
    begin
      rate_legal = rate_ok(v[1:0]) && (v[3:2] == 2'h0);
    end
  endfunction

  // opcodes that the handler knows
  function op_known;
    input [3:0] o;
    begin
      case (o)
        `SSCHD_OP_LDH: op_known = 1'b1;
        `SSCHD_OP_TONE: op_known = 1'b1;
        `SSCHD_OP_ATTEN: op_known = 1'b1;
        `SSCHD_OP_RATE: op_known = 1'b1;
        `SSCHD_OP_LVL: op_known = 1'b1;
        default: op_known = 1'b0;
      endcase
    end
  endfunction

  assign wb_req = cyc_i & stb_i & ~ack_o;
  assign cmd_wr = wb_req & we_i & (adr_i == `SSCHD_ADR_CMD) & sel_i[0];
  assign op = dat_i[`SSCHD_CMD_OP_LSB +: 4];
  assign val = dat_i[`SSCHD_CMD_VAL_LSB +: 4];
  assign ch = dat_i[`SSCHD_CMD_CH_LSB +: 3];
  assign wild = dat_i[`SSCHD_CMD_WILD_BIT];
  assign digs = dat_i[`SSCHD_CMD_DIG_LSB +: NUM_OUT];
  // commands while busy are acked but dropped
  assign cmd_take = cmd_wr & ~busy_ff;
  assign rate_set = cmd_take & (op == `SSCHD_OP_RATE) &
    (val != `SSCHD_VAL_QRY) & rate_legal(val);
  // unknown opcode or rate code flags an error
  assign cmd_bad = ~op_known(op) | ((op == `SSCHD_OP_RATE) &
    (val != `SSCHD_VAL_QRY) & ~rate_legal(val));
  assign stat_rd = wb_req & ~we_i & (adr_i == `SSCHD_ADR_STAT);

  // status flags; a finished write beats a clearing read
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      if (rate_set) begin
        busy_ff <= 1'b1;
        done_ff <= 1'b0;
      end else if (cmd_take) begin
        done_ff <= 1'b1;
      end else if (busy_ff && nv_done_i) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else if (stat_rd) begin
        done_ff <= 1'b0;
      end
      if (cmd_take)
        err_ff <= cmd_bad;
    end
  end
  assign preset_dat_o = {auto_level_report_o, tone_ff, ldh_ff,
    open_mic_atten_o};

  always @* begin
    nxt_atten = open_mic_atten_o;
    for (i = 0; i < NUM_OUT; i = i + 1) begin
      if (wild) begin
        if (val == `SSCHD_VAL_MULTI)
          nxt_atten[i] = digs[i];
        // single value or toggle to all
        else
          nxt_atten[i] = bool_next(open_mic_atten_o[i], val);
      end else if (ch == i) begin
        nxt_atten[i] = bool_next(open_mic_atten_o[i], val);
      end
    end
  end

  // unsupported value leaves settings as they were
  always @* begin
    rep_atten = nxt_atten;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ld_sync_ff <= 3'h0;
      tn_sync_ff <= 3'h0;
      ld_st_ff <= 1'b0;
      tn_st_ff <= 1'b0;
    end else begin
      ld_sync_ff <= {ld_sync_ff[1:0], loop_drop_i};
      tn_sync_ff <= {tn_sync_ff[1:0], tone_detect_i};
      if (ld_sync_ff[1] == ld_sync_ff[2])
        ld_st_ff <= ld_sync_ff[2];
      if (tn_sync_ff[1] == tn_sync_ff[2])
        tn_st_ff <= tn_sync_ff[2];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      hangup_o <= 1'b0;
    end else begin
      // each method gated by its own enable
      hangup_o <= (ldh_ff & ld_st_ff) | (tone_ff & tn_st_ff);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ldh_ff <= 1'b0;
      tone_ff <= 1'b0;
      open_mic_atten_o <= {NUM_OUT{1'b0}};
      auto_level_report_o <= 1'b0;
      line_rate_o <= `SSCHD_RATE_RST;
      reply_ff <= 16'h0000;
      nv_wr_o <= 1'b0;
      nv_dat_o <= `SSCHD_RATE_RST;
    end else begin
      nv_wr_o <= 1'b0;
      if (nv_rate_vld_i && !busy_ff && rate_ok(nv_rate_i))
        line_rate_o <= nv_rate_i;
      if (preset_load_i && !busy_ff) begin
        {auto_level_report_o, tone_ff, ldh_ff, open_mic_atten_o} <=
          preset_dat_i;
      end
      if (cmd_take) begin
        case (op)
          `SSCHD_OP_LDH: begin
            ldh_ff <= bool_next(ldh_ff, val);
            reply_ff <= {15'h0000, bool_next(ldh_ff, val)};
          end
          `SSCHD_OP_TONE: begin
            tone_ff <= bool_next(tone_ff, val);
            reply_ff <= {15'h0000, bool_next(tone_ff, val)};
          end
          `SSCHD_OP_ATTEN: begin
            open_mic_atten_o <= nxt_atten;
            // reply has one bit per output
            reply_ff <= {{(16-NUM_OUT){1'b0}}, rep_atten};
          end
          `SSCHD_OP_LVL: begin
            auto_level_report_o <= bool_next(auto_level_report_o, val);
            reply_ff <= {15'h0000, bool_next(auto_level_report_o, val)};
          end
          `SSCHD_OP_RATE: begin
            if (val == `SSCHD_VAL_QRY) begin
              reply_ff <= {14'h0000, line_rate_o};
            end else if (rate_legal(val)) begin
              line_rate_o <= val[1:0];
              reply_ff <= {14'h0000, val[1:0]};
              nv_wr_o <= 1'b1;
              nv_dat_o <= val[1:0];
            end else begin
              reply_ff <= {14'h0000, line_rate_o};
            end
          end
          default: begin
            reply_ff <= reply_ff;
          end
        endcase
      end
    end
  end

  // single-cycle registered ack; unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      dat_o <= 32'h00000000;
      if (wb_req && !we_i) begin
        case (adr_i)
          `SSCHD_ADR_STAT:
            dat_o <= {13'h0000, reply_ff, err_ff, done_ff, busy_ff};
          `SSCHD_ADR_SET:
            dat_o <= {{(29-NUM_OUT){1'b0}}, auto_level_report_o, tone_ff,
              ldh_ff, open_mic_atten_o};
          `SSCHD_ADR_RATE:
            dat_o <= {30'h00000000, line_rate_o};
          default:
            dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [inc/sschd_consts.vh]
// constants for the serial setting command handler
`ifndef SSCHD_CONSTS_VH
`define SSCHD_CONSTS_VH
`define SSCHD_ADR_CMD 4'h0
`define SSCHD_ADR_STAT 4'h1
`define SSCHD_ADR_SET 4'h2
`define SSCHD_ADR_RATE 4'h3
`define SSCHD_CMD_OP_LSB 0
`define SSCHD_CMD_VAL_LSB 4
`define SSCHD_CMD_CH_LSB 8
`define SSCHD_CMD_WILD_BIT 11
`define SSCHD_CMD_DIG_LSB 12
`define SSCHD_OP_LDH 4'h1
`define SSCHD_OP_TONE 4'h2
`define SSCHD_OP_ATTEN 4'h3
`define SSCHD_OP_RATE 4'h4
`define SSCHD_OP_LVL 4'h5
`define SSCHD_VAL_OFF 4'h0
`define SSCHD_VAL_ON 4'h1
`define SSCHD_VAL_TOG 4'h2
`define SSCHD_VAL_QRY 4'hF
`define SSCHD_VAL_MULTI 4'hE
`define SSCHD_RATE_9600 2'h0
`define SSCHD_RATE_19200 2'h1
`define SSCHD_RATE_38400 2'h2
`define SSCHD_RATE_RST 2'h0
`define SSCHD_STAT_BUSY_BIT 0
`define SSCHD_STAT_DONE_BIT 1
`define SSCHD_STAT_ERR_BIT 2
`endif

// [test/sschd_chk_assertions.sv]
// checker for the serial setting command handler
`timescale 1ns/1ps
`default_nettype none
module sschd_chk #(parameter NUM_OUT = 2) (
  // bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // line and settings
  input wire logic loop_drop_i,
  input wire logic tone_detect_i,
  input wire logic hangup_o,
  input wire logic [NUM_OUT-1:0] open_mic_atten_o,
  input wire logic auto_level_report_o,
  input wire logic [1:0] line_rate_o,
  input wire logic [NUM_OUT+2:0] preset_dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff rst_i;
  wire req = cyc_i && stb_i && !ack_o;
  wire wr = req && we_i && adr_i == 4'h0;
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_reply: assert property (req |=> ack_o)
    else $error("request not answered");
  a_rate_legal: assert property (line_rate_o != 2'h3)
    else $error("illegal rate code");
  a_rate_read: assert property (ack_o && $past(req && adr_i == 4'h3
    && !we_i) |-> dat_o == {30'h0, line_rate_o})
    else $error("rate read wrong");
  a_loop_hang: assert property ((loop_drop_i && preset_dat_o[2])[*8]
    |-> hangup_o) else $error("no hangup on drop");
  a_no_hang: assert property (((!loop_drop_i || !preset_dat_o[2]) &&
    (!tone_detect_i || !preset_dat_o[3]))[*8] |-> !hangup_o)
    else $error("hangup without cause");
  a_lvl_on: assert property (ack_o && $past(wr && dat_i[7:0] == 8'h15)
    |-> auto_level_report_o) else $error("level report not on");
  a_wild_all: assert property (ack_o && $past(wr && dat_i[11:0] ==
    12'h813) |-> &open_mic_atten_o) else $error("wildcard set missed");
endmodule
bind sschd_top sschd_chk #(.NUM_OUT(NUM_OUT)) sschd_chk_inst (.*);
`default_nettype wire

// [test/sschd_nvm.sv]
// global storage model: slow write, rate restore after reset
`timescale 1ns/1ps
`default_nettype none
module sschd_nvm #(parameter DLY = 20) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // storage port
  input wire logic wr_i,
  input wire logic [1:0] dat_i,
  output logic done_o,
  output logic [1:0] rate_o,
  output logic vld_o
);
  int cnt_ff = 0;
  logic [1:0] st_ff = 2'h0;
  always @(posedge clk_i) begin
    vld_o <= rst_i;
    done_o <= cnt_ff == 1;
    if (wr_i) begin
      st_ff <= dat_i;
      cnt_ff <= DLY;
    end else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
  end
  // garbage outside the restore pulse
  assign rate_o = vld_o ? st_ff : ~st_ff;
endmodule
`default_nettype wire

// [test/sschd_tb_top.sv]
// testbench for the serial setting command handler
`timescale 1ns/1ps
`default_nettype none
module sschd_tb_top;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
  logic we_i = 1'h0, loop_drop_i = 1'h0, tone_detect_i = 1'h0;
  logic preset_load_i = 1'h0, ack_o, hangup_o, auto_level_report_o;
  logic nv_wr_o, nv_done_i, nv_rate_vld_i;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [1:0] open_mic_atten_o, line_rate_o, nv_dat_o, nv_rate_i, r;
  logic [4:0] preset_dat_i = 5'h0, preset_dat_o;
  int errors = 0, compares = 0, cyc_n = 0;
  sschd_top #(.NUM_OUT(2)) sschd_top_inst (.*);
  sschd_nvm #(.DLY(20)) sschd_nvm_inst (.clk_i, .rst_i, .wr_i(nv_wr_o),
    .dat_i(nv_dat_o), .done_o(nv_done_i), .rate_o(nv_rate_i),
    .vld_o(nv_rate_vld_i));
  always #10 clk_i = ~clk_i;
  task finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) if (++cyc_n == 5000) begin
    errors++;
    finish_test();
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // one classic cycle, release after the ack edge
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    int n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'h1 && ++n < 50);
    if (n == 50) errors++;
    rd = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic cmd(logic [15:0] c);
    wb(1'h1, 4'h0, {16'h0, c});
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    cmd(16'h0011);
    wb(1'h0, 4'h1, 32'h0);
    chk("loop on", 32'h1, rd[3]);
    cmd(16'h0021);
    cmd(16'h00F1);
    wb(1'h0, 4'h1, 32'h0);
    chk("loop tog", 32'h0, {preset_dat_o[2], rd[3]});
    cmd(16'h0011);
    loop_drop_i <= 1'h1;
    repeat (10) @(posedge clk_i);
    chk("hang loop", 32'h1, hangup_o);
    {loop_drop_i, tone_detect_i} <= 2'h1;
    repeat (10) @(posedge clk_i);
    chk("tone off", 32'h0, hangup_o);
    cmd(16'h0012);
    repeat (10) @(posedge clk_i);
    chk("tone on", 32'h3, {preset_dat_o[2], hangup_o});
    tone_detect_i <= 1'h0;
    $display("hangup test done");
    cmd(16'h0813);
    chk("atten all", 32'h3, open_mic_atten_o);
    cmd(16'h18E3);
    chk("atten each", 32'h1, open_mic_atten_o);
    cmd(16'h0823);
    wb(1'h0, 4'h1, 32'h0);
    chk("atten tog", 32'hA, {open_mic_atten_o, rd[4:3]});
    cmd(16'h0103);
    chk("atten one", 32'h0, open_mic_atten_o);
    cmd(16'h0015);
    chk("lvl on", 32'h1, auto_level_report_o);
    cmd(16'h0025);
    wb(1'h0, 4'h1, 32'h0);
    chk("lvl tog", 32'h0, {auto_level_report_o, rd[3]});
    $display("setting test done");
    for (int k = 0; k < 3; k++) begin
      r = 2'((k + 2) % 3);
      cmd({10'h0, r, 4'h4});
      wb(1'h0, 4'h1, 32'h0);
      chk("rate busy", {r, 1'h1}, {line_rate_o, rd[0]});
      repeat (30) @(posedge clk_i);
      wb(1'h0, 4'h1, 32'h0);
      chk("rate done", 32'h2, rd[1:0]);
      wb(1'h0, 4'h3, 32'h0);
      chk("rate read", r, rd);
    end
    cmd(16'h0034);
    wb(1'h0, 4'h3, 32'h0);
    chk("rate bad", 32'h1, rd);
    wb(1'h0, 4'h1, 32'h0);
    chk("rate err", 32'h1, rd[2]);
    wb(1'h0, 4'h7, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("rate test done");
    {preset_load_i, preset_dat_i} <= 6'h35;
    @(posedge clk_i);
    preset_load_i <= 1'h0;
    @(posedge clk_i);
    chk("preset", 32'h15, preset_dat_o);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk("restore", 32'h20, {line_rate_o, preset_dat_o});
    $display("storage test done");
    finish_test();
  end
endmodule
`default_nettype wire
